// ---- cwb_core.sv ----
/*
 * cwb_core: four-output complementary waveform generator with
 * half-bridge, push-pull, full-bridge and steering modes, two 6-bit
 * dead-band counters and an AHB-Lite register slave.
 * Assumes data sources and dead-band clock ticks synchronous to hclk.
 */
//
// Behaviour
// - full-bridge direction bit changes apply at next data rising edge.
// - forward to reverse swaps a/c levels, d goes inactive, b modulates.
// - newly modulated output stays inactive until direction dead band ends.
// - full-bridge dead band only on direction change, only modulated output.
// - steering routes input to any output set, others fixed, no dead band.
// - steer enable clear holds override level, set passes modulated input.
// - polarity applies only to steered outputs, overrides pass unchanged.
// - steer enables are synchronised, override data bits are not.
// - in steering, shutdown overrides only steered outputs.
// - synchronous steering defers changes to next data rising edge.
// - asynchronous steering applies changes right after the write.
// - dead-band timing ticks from system clock or internal oscillator.
// - oscillator selection requests it stay alive in sleep while enabled.
// - a 5-bit field selects the data input source.
// - polarity set means active high, clear means active low.
// - two 6-bit counters: rising/reverse and falling/forward.
// - dead band counts clock periods from zero up to the stored value.
// - half-bridge out_a turns on after rising dead band.
// - reverse dead band only on forward to reverse, delays out_b only.
// - dead band starts on input edge, zero count means none.
// - input reversing before count ends suppresses that pulse.
// - dead-band counts double-buffered, load via request after falling edge.
// - mode 010: a active, b and c inactive, d modulated.
// - mode 011: c active, a and d inactive, b modulated.
`timescale 1ns/1ps
module cwb_core #(
   parameter int NSRC = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [NSRC-1:0] data_src,
   input wire logic hf_osc_tick,
   input wire logic sleep_mode,
   input wire logic shutdown_in_n,
   output logic hf_osc_keep_awake,
   output logic [3:0] out_pin
);
   // register state
   logic en;
   logic buffer_load_request;
   logic [2:0] mode;
   logic [3:0] polarity_select;
   logic [5:0] dbr_shadow;
   logic [5:0] dbf_shadow;
   logic [5:0] rising_deadband_count;
   logic [5:0] falling_deadband_count;
   logic clock_source_select;
   logic [4:0] input_source_select;
   logic [3:0] steer_enable;
   logic [3:0] override_level;
   logic sd_sw;
   logic [3:0] sd_level;
   // bus data-phase state
   logic wr_pend;
   logic [7:0] wr_addr;
   // datapath state
   logic data_s;
   logic data_prev;
   logic ld_armed;
   logic [3:0] steer_act;
   logic dir;
   logic pp_sel;
   logic [1:0] busy;
   logic [1:0] on;
   logic [5:0] cnt [2];
   logic [3:0] next_out;

   // bus decode
   wire addr_ok = hsel && hready && htrans[1];
   wire wr_ctrl = wr_pend && wr_addr == cwb_pkg::OFS_CTRL;
   wire wr_dbr = wr_pend && wr_addr == cwb_pkg::OFS_DBR;
   wire wr_dbf = wr_pend && wr_addr == cwb_pkg::OFS_DBF;
   wire wr_steer = wr_pend && wr_addr == cwb_pkg::OFS_STEER;
   wire wr_shdn = wr_pend && wr_addr == cwb_pkg::OFS_SHDN;
   wire [7:0] rd_addr = haddr[7:0];
   logic [31:0] rd_mux;

   // datapath decode
   wire d_rise = data_s && !data_prev;
   wire d_fall = !data_s && data_prev;
   wire steer_mode = mode[2:1] == 2'b00;
   wire fb_mode = mode[2:1] == 2'b01;
   wire hb_mode = mode == cwb_pkg::MODE_HALF;
   wire dir_chg = en && fb_mode && d_rise && mode[0] != dir;
   wire db_load = ld_armed && d_rise;
   // sequencer steps on the edge itself, so the first pulse never leaks onto out_b
   wire pp_now = pp_sel ^ d_rise;
   wire sd = sd_sw || !shutdown_in_n;
   // system clock is stopped in sleep, so its dead band stalls there
   wire db_tick = clock_source_select ? hf_osc_tick : !sleep_mode;
   wire [1:0] start;
   wire [1:0] cancel;
   wire [5:0] db_val [2];
   wire fb_mod;
   wire [3:0] pre;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hf_osc_keep_awake = en && clock_source_select;

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (rd_addr)
         cwb_pkg::OFS_CTRL: begin
            rd_mux[cwb_pkg::CTRL_EN] = en;
            rd_mux[cwb_pkg::CTRL_LD] = buffer_load_request;
            rd_mux[2:0] = mode;
         end
         cwb_pkg::OFS_POL: rd_mux[3:0] = polarity_select;
         cwb_pkg::OFS_DBR: rd_mux[5:0] = dbr_shadow;
         cwb_pkg::OFS_DBF: rd_mux[5:0] = dbf_shadow;
         cwb_pkg::OFS_CLK: rd_mux[0] = clock_source_select;
         cwb_pkg::OFS_ISM: rd_mux[4:0] = input_source_select;
         cwb_pkg::OFS_STEER: begin
            rd_mux[3:0] = steer_enable;
            rd_mux[11:8] = override_level;
         end
         cwb_pkg::OFS_SHDN: begin
            rd_mux[0] = sd;
            rd_mux[7:4] = sd_level;
         end
         cwb_pkg::OFS_STAT: rd_mux[17:0] = {dir, pp_sel, busy, on, steer_act, 4'h0, out_pin};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // zero wait states: read data is latched at the address-phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en <= 1'b0;
         mode <= cwb_pkg::RST_MODE;
         polarity_select <= cwb_pkg::RST_POL;
         clock_source_select <= 1'b0;
         input_source_select <= cwb_pkg::RST_ISM;
         steer_enable <= cwb_pkg::RST_STEER;
         override_level <= cwb_pkg::RST_STEER;
         sd_level <= cwb_pkg::RST_SDLVL;
      end else if (wr_pend) begin
         case (wr_addr)
            cwb_pkg::OFS_CTRL: begin
               en <= hwdata[cwb_pkg::CTRL_EN];
               mode <= hwdata[cwb_pkg::CTRL_MODE +: 3];
            end
            cwb_pkg::OFS_POL: polarity_select <= hwdata[3:0];
            cwb_pkg::OFS_CLK: clock_source_select <= hwdata[0];
            cwb_pkg::OFS_ISM: input_source_select <= hwdata[4:0];
            cwb_pkg::OFS_STEER: begin
               steer_enable <= hwdata[cwb_pkg::STEER_EN +: 4];
               override_level <= hwdata[cwb_pkg::STEER_DAT +: 4];
            end
            cwb_pkg::OFS_SHDN: sd_level <= hwdata[cwb_pkg::SHDN_LVL +: 4];
            default: ;
         endcase
      end
   end

   // shutdown bit cannot be cleared while the external request persists
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sd_sw <= cwb_pkg::RST_SD;
      end else if (!shutdown_in_n) begin
         sd_sw <= 1'b1;
      end else if (wr_shdn) begin
         sd_sw <= hwdata[cwb_pkg::SHDN_SW];
      end
   end

   // double-buffered dead-band counts; a new request wins over the hw clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dbr_shadow <= cwb_pkg::RST_DB;
         dbf_shadow <= cwb_pkg::RST_DB;
         rising_deadband_count <= cwb_pkg::RST_DB;
         falling_deadband_count <= cwb_pkg::RST_DB;
         buffer_load_request <= 1'b0;
         ld_armed <= 1'b0;
      end else begin
         if (wr_dbr) begin
            dbr_shadow <= hwdata[5:0];
         end
         if (wr_dbf) begin
            dbf_shadow <= hwdata[5:0];
         end
         if (!en && wr_dbr) begin
            rising_deadband_count <= hwdata[5:0];
         end else if (en && db_load) begin
            rising_deadband_count <= dbr_shadow;
         end
         if (!en && wr_dbf) begin
            falling_deadband_count <= hwdata[5:0];
         end else if (en && db_load) begin
            falling_deadband_count <= dbf_shadow;
         end
         if (wr_ctrl && hwdata[cwb_pkg::CTRL_LD]) begin
            buffer_load_request <= 1'b1;
         end else if (db_load) begin
            buffer_load_request <= 1'b0;
         end
         if (!en || db_load) begin
            ld_armed <= 1'b0;
         end else if (buffer_load_request && d_fall) begin
            ld_armed <= 1'b1;
         end
      end
   end

   // input sampling, edge memory, direction and steering latches
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_s <= 1'b0;
         data_prev <= 1'b0;
         dir <= 1'b0;
         pp_sel <= 1'b0;
         steer_act <= cwb_pkg::RST_STEER;
      end else begin
         data_s <= data_src[input_source_select];
         data_prev <= data_s;
         if (!en) begin
            dir <= mode[0];
         end else if (dir_chg) begin
            dir <= mode[0];
         end
         if (!en || sd) begin
            pp_sel <= 1'b0;
         end else if (d_rise) begin
            pp_sel <= !pp_sel;
         end
         if (!en || mode == cwb_pkg::MODE_ASTEER) begin
            steer_act <= steer_enable;
         end else if (d_rise) begin
            steer_act <= steer_enable;
         end
      end
   end

   // index 0: rising edge / reverse, index 1: falling edge / forward
   assign start[0] = hb_mode ? d_rise : (dir_chg && mode[0]);
   assign start[1] = hb_mode ? d_fall : (dir_chg && !mode[0]);
   assign cancel[0] = hb_mode && d_fall;
   assign cancel[1] = hb_mode && d_rise;
   // a count loaded on the starting edge already times that edge, start and end alike
   assign db_val[0] = (en && db_load) ? dbr_shadow : rising_deadband_count;
   assign db_val[1] = (en && db_load) ? dbf_shadow : falling_deadband_count;

   for (genvar i = 0; i < 2; i++) begin : g_db
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            busy[i] <= 1'b0;
            on[i] <= 1'b0;
            cnt[i] <= 6'h00;
         end else if (!en || cancel[i]) begin
            busy[i] <= 1'b0;
            on[i] <= 1'b0;
         end else if (start[i]) begin
            cnt[i] <= 6'h00;
            busy[i] <= db_val[i] != 6'h00;
            on[i] <= db_val[i] == 6'h00;
         end else if (busy[i] && db_tick) begin
            cnt[i] <= cnt[i] + 6'h01;
            if (cnt[i] + 6'h01 == db_val[i]) begin
               busy[i] <= 1'b0;
               on[i] <= 1'b1;
            end
         end
      end
   end

   // modulated full-bridge output is held off while its counter runs
   assign fb_mod = data_s && !(dir ? busy[0] : busy[1]);
   assign pre = fb_mode ? (dir ? {1'b0, 1'b1, fb_mod, 1'b0}
                               : {fb_mod, 1'b0, 1'b0, 1'b1})
              : hb_mode ? {on[1], on[0], on[1], on[0]}
              : {data_s && !pp_now, data_s && pp_now, data_s && !pp_now, data_s && pp_now};

   for (genvar i = 0; i < 4; i++) begin : g_out
      always_comb begin
         if (!en) begin
            next_out[i] = 1'b0;
         end else if (steer_mode && !steer_act[i]) begin
            next_out[i] = override_level[i];
         end else if (sd) begin
            next_out[i] = sd_level[i];
         end else if (steer_mode) begin
            next_out[i] = data_s ^ !polarity_select[i];
         end else begin
            next_out[i] = pre[i] ^ !polarity_select[i];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_pin <= 4'h0;
      end else begin
         out_pin <= next_out;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_ovr;
      en && steer_mode && !steer_act[0] |-> next_out[0] == override_level[0];
   endproperty
   a_ovr: assert property (p_ovr) else $error("override level not held");

   property p_pol;
      en && steer_mode && steer_act[1] && !sd |-> next_out[1] == (data_s ^ !polarity_select[1]);
   endproperty
   a_pol: assert property (p_pol) else $error("steered polarity wrong");

   property p_sync;
      en && mode == cwb_pkg::MODE_SSTEER && !d_rise |=> $stable(steer_act);
   endproperty
   a_sync: assert property (p_sync) else $error("sync steering changed off edge");

   property p_async;
      en && mode == cwb_pkg::MODE_ASTEER |=> steer_act == $past(steer_enable);
   endproperty
   a_async: assert property (p_async) else $error("async steering late");

   property p_fwd;
      en && !sd && fb_mode && !dir |-> next_out[0] == polarity_select[0] && next_out[2] == !polarity_select[2];
   endproperty
   a_fwd: assert property (p_fwd) else $error("forward static levels wrong");

   property p_rev_hold;
      en && !sd && fb_mode && dir && busy[0] |-> next_out[1] == !polarity_select[1];
   endproperty
   a_rev_hold: assert property (p_rev_hold) else $error("out_b modulated in dead band");

   property p_zero_db;
      en && hb_mode && d_rise && db_val[0] == 6'h00 |=> on[0] && !busy[0];
   endproperty
   a_zero_db: assert property (p_zero_db) else $error("zero dead band delayed");

   property p_cancel;
      en && hb_mode && d_fall |=> !on[0] && !busy[0];
   endproperty
   a_cancel: assert property (p_cancel) else $error("pulse not suppressed");

   property p_load;
      en && $changed(rising_deadband_count) |-> $past(ld_armed && d_rise);
   endproperty
   a_load: assert property (p_load) else $error("dead band loaded off edge");

   property p_dirchg;
      dir_chg |=> dir == $past(mode[0]);
   endproperty
   a_dirchg: assert property (p_dirchg) else $error("direction not taken");

   c_dir: cover property (dir_chg ##1 busy[0]);
   c_db_done: cover property (hb_mode && busy[0] ##1 on[0]);
   c_sync: cover property (mode == cwb_pkg::MODE_SSTEER && d_rise && steer_act != steer_enable);
   c_load: cover property (db_load && en);
endmodule // cwb_core

// ---- cwb_pkg.sv ----
/*
 * cwb_pkg: register map, field positions, reset values and mode codes
 * of the complementary waveform bridge and steering block.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package cwb_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_POL = 8'h04;
   localparam logic [7:0] OFS_DBR = 8'h08;
   localparam logic [7:0] OFS_DBF = 8'h0c;
   localparam logic [7:0] OFS_CLK = 8'h10;
   localparam logic [7:0] OFS_ISM = 8'h14;
   localparam logic [7:0] OFS_STEER = 8'h18;
   localparam logic [7:0] OFS_SHDN = 8'h1c;
   localparam logic [7:0] OFS_STAT = 8'h20;
   // control register fields
   localparam int CTRL_EN = 7;
   localparam int CTRL_LD = 6;
   localparam int CTRL_MODE = 0;
   // steering register fields: enables low nibble, override data at 8
   localparam int STEER_EN = 0;
   localparam int STEER_DAT = 8;
   // shutdown register fields
   localparam int SHDN_SW = 0;
   localparam int SHDN_LVL = 4;
   // reset values
   localparam logic [2:0] RST_MODE = 3'h0;
   localparam logic [3:0] RST_POL = 4'hf;
   localparam logic [5:0] RST_DB = 6'h00;
   localparam logic [4:0] RST_ISM = 5'h00;
   localparam logic [3:0] RST_STEER = 4'h0;
   localparam logic [3:0] RST_SDLVL = 4'h0;
   localparam logic RST_SD = 1'b1;

   typedef enum logic [2:0] {
      MODE_ASTEER = 3'b000,
      MODE_SSTEER = 3'b001,
      MODE_FWD = 3'b010,
      MODE_REV = 3'b011,
      MODE_HALF = 3'b100,
      MODE_PUSH = 3'b101
   } cwb_mode_e;
endpackage

// ---- cwb_bridge_drv.sv ----
/*
 * cwb_bridge_drv: behavioural model of the bridge switch drivers.
 * Assumes out_pin bits a..d, active-high drivers, a/b and c/d per leg.
 */
`timescale 1ns/1ps
module cwb_bridge_drv (
   input wire logic hclk,
   input wire logic [3:0] out_pin,
   input wire logic fault,
   input wire logic arm,
   output logic shutdown_in_n,
   output int shoot
);
   // open-drain fault line, pulled up when released
   assign shutdown_in_n = fault ? 1'b0 : 1'b1;
   initial shoot = 0;
   // both switches of one leg on means shoot-through
   always @(posedge hclk) begin
      if (arm && ((out_pin[0] && out_pin[1]) || (out_pin[2] && out_pin[3]))) begin
         shoot <= shoot + 1;
      end
   end
endmodule // cwb_bridge_drv

// ---- complementary_waveform_bridge_steering_test.sv ----
/*
 * complementary_waveform_bridge_steering_test: self-checking bench.
 * Assumes cwb_core with zero-wait AHB-Lite slave and data on data_src[5].
 */
`timescale 1ns/1ps
module complementary_waveform_bridge_steering_test;
   logic hclk, hresetn, hwrite, hready, hresp, fault, arm, sleep_mode, hf_osc_tick, tick_en;
   logic shutdown_in_n, hf_osc_keep_awake, hi;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, data_src, q;
   logic [3:0] out_pin;
   int shoot, n_fail, checks_done, n0, n;

   cwb_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .data_src(data_src), .hf_osc_tick(hf_osc_tick),
      .sleep_mode(sleep_mode), .shutdown_in_n(shutdown_in_n),
      .hf_osc_keep_awake(hf_osc_keep_awake), .out_pin(out_pin));
   cwb_bridge_drv drv_u (.hclk(hclk), .out_pin(out_pin), .fault(fault), .arm(arm),
      .shutdown_in_n(shutdown_in_n), .shoot(shoot));

   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // oscillator ticks at half the system rate
   always @(posedge hclk) hf_osc_tick <= tick_en & ~hf_osc_tick;

   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task setd(input logic v);
      @(posedge hclk);
      data_src[5] <= v;
      repeat (4) @(posedge hclk);
   endtask
   // enable off while reconfiguring, so the count loads at once
   task cfg(input logic [2:0] m, input logic [3:0] p, input logic [31:0] s, input logic [5:0] db);
      bus(1'b1, cwb_pkg::OFS_CTRL, 32'h0);
      bus(1'b1, cwb_pkg::OFS_DBR, {26'h0, db});
      bus(1'b1, cwb_pkg::OFS_POL, {28'h0, p});
      bus(1'b1, cwb_pkg::OFS_STEER, s);
      bus(1'b1, cwb_pkg::OFS_SHDN, 32'h50);
      bus(1'b1, cwb_pkg::OFS_CTRL, {24'h0, 5'h10, m});
   endtask
   task meas(input int b, output int c);
      @(posedge hclk);
      data_src[5] <= 1'b1;
      c = 0;
      do begin
         @(posedge hclk);
         c++;
      end while (out_pin[b] !== 1'b1 && c < 100);
   endtask

   task t_reset;
      chk({28'h0, out_pin}, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      bus(1'b0, cwb_pkg::OFS_POL, 32'h0);
      chk(q, {28'h0, cwb_pkg::RST_POL});
      bus(1'b0, cwb_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      bus(1'b1, cwb_pkg::OFS_ISM, 32'h5);
      $display("test reset done");
   endtask
   task t_async;
      cfg(cwb_pkg::MODE_ASTEER, 4'h5, 32'h0803, 6'h0);
      setd(1'b1);
      chk({28'h0, out_pin}, 32'h9);
      @(posedge hclk);
      data_src[4] <= 1'b1;
      setd(1'b0);
      chk({28'h0, out_pin}, 32'ha);
      setd(1'b1);
      bus(1'b1, cwb_pkg::OFS_STEER, 32'h0a01);
      repeat (3) @(posedge hclk);
      chk({28'h0, out_pin}, 32'hb);
      setd(1'b0);
      $display("test async steering done");
   endtask
   task t_sync;
      cfg(cwb_pkg::MODE_SSTEER, 4'hf, 32'h0001, 6'h0);
      setd(1'b1);
      chk({28'h0, out_pin}, 32'h1);
      bus(1'b1, cwb_pkg::OFS_STEER, 32'h0002);
      repeat (4) @(posedge hclk);
      chk({28'h0, out_pin}, 32'h1);
      setd(1'b0);
      setd(1'b1);
      chk({28'h0, out_pin}, 32'h2);
      setd(1'b0);
      $display("test sync steering done");
   endtask
   task t_shdn;
      cfg(cwb_pkg::MODE_ASTEER, 4'hf, 32'h0c03, 6'h0);
      setd(1'b1);
      chk({28'h0, out_pin}, 32'hf);
      fault <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({28'h0, out_pin}, 32'hd);
      fault <= 1'b0;
      bus(1'b1, cwb_pkg::OFS_SHDN, 32'h50);
      repeat (3) @(posedge hclk);
      chk({28'h0, out_pin}, 32'hf);
      setd(1'b0);
      $display("test shutdown done");
   endtask
   task t_half;
      arm <= 1'b1;
      cfg(cwb_pkg::MODE_HALF, 4'hf, 32'h0, 6'h0);
      meas(0, n0);
      setd(1'b0);
      cfg(cwb_pkg::MODE_HALF, 4'hf, 32'h0, 6'h3);
      meas(0, n);
      setd(1'b0);
      chk(32'(n), 32'(n0 + 3));
      bus(1'b1, cwb_pkg::OFS_DBR, 32'h7);
      meas(0, n);
      setd(1'b0);
      chk(32'(n), 32'(n0 + 3));
      bus(1'b1, cwb_pkg::OFS_CTRL, 32'hc4);
      meas(0, n);
      setd(1'b0);
      meas(0, n);
      setd(1'b0);
      chk(32'(n), 32'(n0 + 7));
      // oscillator ticks stretch the count and survive sleep
      cfg(cwb_pkg::MODE_HALF, 4'hf, 32'h0, 6'h3);
      bus(1'b1, cwb_pkg::OFS_CLK, 32'h1);
      @(posedge hclk);
      chk({31'h0, hf_osc_keep_awake}, 32'h1);
      tick_en <= 1'b1;
      sleep_mode <= 1'b1;
      meas(0, n);
      setd(1'b0);
      chk({31'h0, n >= n0 + 5 && n <= n0 + 7}, 32'h1);
      tick_en <= 1'b0;
      sleep_mode <= 1'b0;
      bus(1'b1, cwb_pkg::OFS_CLK, 32'h0);
      @(posedge hclk);
      chk({31'h0, hf_osc_keep_awake}, 32'h0);
      // a pulse shorter than the dead band never appears
      cfg(cwb_pkg::MODE_HALF, 4'hf, 32'h0, 6'ha);
      hi = 1'b0;
      @(posedge hclk);
      data_src[5] <= 1'b1;
      repeat (4) @(posedge hclk) hi = hi | out_pin[0];
      data_src[5] <= 1'b0;
      repeat (20) @(posedge hclk) hi = hi | out_pin[0];
      chk({31'h0, hi}, 32'h0);
      chk(32'(shoot), 32'h0);
      $display("test half bridge done");
   endtask
   // first pulse of the pair on a/c, second on b/d, no stray cycle on out_b
   task t_push;
      cfg(cwb_pkg::MODE_PUSH, 4'hb, 32'h0, 6'h0);
      hi = 1'b0;
      @(posedge hclk);
      data_src[5] <= 1'b1;
      repeat (4) @(posedge hclk) hi = hi | out_pin[1];
      chk({31'h0, hi}, 32'h0);
      chk({28'h0, out_pin}, 32'h1);
      setd(1'b0);
      chk({28'h0, out_pin}, 32'h4);
      setd(1'b1);
      chk({28'h0, out_pin}, 32'he);
      setd(1'b0);
      $display("test push-pull done");
   endtask
   task t_full;
      cfg(cwb_pkg::MODE_FWD, 4'hf, 32'h0, 6'h6);
      arm <= 1'b1;
      setd(1'b1);
      chk({28'h0, out_pin}, 32'h9);
      setd(1'b0);
      chk({28'h0, out_pin}, 32'h1);
      bus(1'b1, cwb_pkg::OFS_CTRL, 32'h83);
      repeat (4) @(posedge hclk);
      chk({28'h0, out_pin}, 32'h1);
      meas(1, n);
      chk({31'h0, n >= n0 + 6 && n <= n0 + 8}, 32'h1);
      chk({28'h0, out_pin}, 32'h6);
      setd(1'b0);
      chk({28'h0, out_pin}, 32'h4);
      chk(32'(shoot), 32'h0);
      arm <= 1'b0;
      $display("test full bridge done");
   endtask

   task results;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge hclk);
      n_fail++;
      results();
   end
   initial begin
      n_fail = 0;
      checks_done = 0;
      hresetn = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      data_src = 32'h10;
      fault = 1'b0;
      arm = 1'b0;
      sleep_mode = 1'b0;
      tick_en = 1'b0;
      hf_osc_tick = 1'b0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_async();
      t_sync();
      t_shdn();
      t_push();
      t_half();
      t_full();
      results();
   end
endmodule // complementary_waveform_bridge_steering_test
